//--- verilog/acsm_pkg.sv
// Audio channel sequencer constants, states and register map
package acsm_pkg;
  // Sequencer codes as the state flip-flops hold them
  typedef enum logic [2:0] {
    ST_IDLE      = 3'h0,
    ST_DMA_WAIT  = 3'h1,
    ST_HI        = 3'h2,
    ST_LO        = 3'h3,
    ST_UNUSED4   = 3'h4,
    ST_DMA_PRIME = 3'h5,
    ST_UNUSED6   = 3'h6,
    ST_UNUSED7   = 3'h7
  } acsm_state_t;

  // Sequencer step rate derived from the system clock
  localparam int SYS_CLK_KHZ = 200000;
  localparam int CC_KHZ      = 3580;
  localparam int TICK_DIV    = SYS_CLK_KHZ / CC_KHZ;
  localparam int TICK_W      = $clog2(TICK_DIV);

  // Register port
  localparam int         ADDR_W = 3;
  localparam logic [2:0] A_PER  = 3'h0;
  localparam logic [2:0] A_LEN  = 3'h1;
  localparam logic [2:0] A_VOL  = 3'h2;
  localparam logic [2:0] A_DAT  = 3'h3;
  localparam logic [2:0] A_CTL  = 3'h4;
  localparam logic [2:0] A_STAT = 3'h5;

  // Control fields
  localparam int CTL_AV = 0;
  localparam int CTL_AP = 1;

  // Status fields above the three state bits
  localparam int STAT_FULL = 3;
  localparam int STAT_PREP = 4;
  localparam int STAT_RST  = 5;

  // Counter finish value and latch reset values
  localparam logic [15:0] CNT_FIN   = 16'h0001;
  localparam logic [15:0] PER_RST   = 16'h0000;
  localparam logic [15:0] LEN_RST   = 16'h0000;
  localparam logic [6:0]  VOL_RST   = 7'h00;
endpackage : acsm_pkg

//--- verilog/acsm_channel.sv
// One audio channel sequencer with counters, requests and attach forwarding
//
// The address map and the plain strobed port were decided locally.
`timescale 1ns/1ps

// Behaviour
// RL1: Per-channel eight-state sequencer, three state bits, stepped at the 3.58 MHz rate.
// RL2: The three unused state codes return unconditionally to idle 000.
// RL3: Without DMA, a processor data write moves idle into main loop 010/011.
// RL4: State 010 outputs the high byte, state 011 the low byte.
// RL5: Main loop moves only when period counter is one; counter reloads then.
// RL6: Processor must clear pending interrupt in time, otherwise sequencer falls idle.
// RL7: Without DMA, an interrupt request is raised on every 011 to 010 move except with attach period alone set.
// RL8: DMA on moves idle to 001 and issues word requests.
// RL9: First DMA word is discarded; it moves to 101 with next request out.
// RL10: Next DMA word enters 010; loop runs until DMA turns off.
// RL11: Length counts per word; at one, restart request joins word request, reload.
// RL12: In DMA mode, interrupt follows length finish as last word starts output.
// RL13: DMA controller collects requests per line, returns data about 14 cycles later.
// RL14: Attach volume requests on 011-010, attach period on 010-011, both on both.
// RL15: With very short periods the two buffered bytes simply repeat.
// RL16: Attach volume forwards words to next channel volume latch, not converter.
// RL17: Attach period forwards words to next channel period latch, not converter.
// RL18: Interrupt output combines immediate term and prepared term fired at 011-010 or 101-010.
// RL19: Period, length, volume reload from own latches; finished means value one.
// RL20: Output buffer loads from holding latch; second path on 010-011 with attach period.
// RL21: Normal requests qualified by no attach mode or attach volume.
// RL22: Each data load moves a full 16-bit word into the holding latch.
// RL23: Reset leaves the sequencer idle with no requests asserted.
module acsm_channel #(
  parameter int DAT_W = 16,
  parameter int VOL_W = 7
) (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       sys_rst,
  // Register port
  input  wire logic [acsm_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [15:0]                reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic      [15:0]                reg_rdata,
  // DMA controller and interrupt circuitry
  input  wire logic                       chan_dma_on,
  input  wire logic                       chan_irq_pending,
  input  wire logic                       dma_data_valid,
  input  wire logic [DAT_W-1:0]           dma_data,
  output logic                            chan_word_dma_req,
  output logic                            chan_ptr_restart_req,
  output logic                            chan_irq_request,
  // From the previous channel when it is attached
  input  wire logic                       prev_per_load,
  input  wire logic                       prev_vol_load,
  input  wire logic [15:0]                prev_data,
  // To the next channel
  output logic                            fwd_per_load,
  output logic                            fwd_vol_load,
  output logic      [DAT_W-1:0]           fwd_data,
  // Converter side
  output logic      [7:0]                 dac_out,
  output logic      [VOL_W-1:0]           vol_out,
  output logic      [2:0]                 state_bits
);

  if (DAT_W != 16 || VOL_W < 1 || VOL_W > 16) begin : g_chk
    $error("acsm_channel: unsupported width");
  end

  acsm_pkg::acsm_state_t st;
  acsm_pkg::acsm_state_t next_st;

  logic [acsm_pkg::TICK_W-1:0] tick_cnt;
  logic             tick;
  logic [15:0]      per_latch;
  logic [15:0]      per_cnt;
  logic [15:0]      len_latch;
  logic [15:0]      len_cnt;
  logic [VOL_W-1:0] vol_latch;
  logic [DAT_W-1:0] hold;
  logic [DAT_W-1:0] outbuf;
  logic             hold_full;
  logic             irq_term_prepared;
  logic             restart_pend;
  logic             attach_volume;
  logic             attach_period;
  logic             napnav;
  logic             attached;
  logic             per_fin;
  logic             len_fin;
  logic             dat_wr;
  logic             word_in;
  logic             outbuf_load_main;
  logic             outbuf_load_attach;
  logic             consume;
  logic             next_req;
  logic             irq_term_now;
  logic             per_rld;
  logic             len_rld;
  logic             fire_prep;

  // Step strobe at the clock constant rate
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tick_cnt <= '0;
    end else if (tick) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick_cnt + 1'b1;
    end
  end
  // RL1: sequencer step rate
  assign tick = (tick_cnt == acsm_pkg::TICK_W'(acsm_pkg::TICK_DIV - 1));

  // RL21: request qualifier
  assign napnav   = ~attach_period | attach_volume;
  assign attached = attach_period | attach_volume;
  // RL19: finished means value one
  assign per_fin  = (per_cnt == acsm_pkg::CNT_FIN);
  assign len_fin  = (len_cnt == acsm_pkg::CNT_FIN);
  assign dat_wr   = reg_wr && (reg_addr == acsm_pkg::A_DAT);
  // Discarded first word is not counted
  assign word_in  = dma_data_valid && chan_dma_on && (st != acsm_pkg::ST_DMA_WAIT);

  always_comb begin
    next_st            = st;
    outbuf_load_main   = 1'b0;
    outbuf_load_attach = 1'b0;
    consume            = 1'b0;
    next_req           = 1'b0;
    irq_term_now       = 1'b0;
    per_rld            = 1'b0;
    len_rld            = 1'b0;
    fire_prep          = 1'b0;
    if (tick) begin
      case (st)
        acsm_pkg::ST_IDLE: begin
          // RL8: DMA start
          if (chan_dma_on) begin
            next_st  = acsm_pkg::ST_DMA_WAIT;
            next_req = 1'b1;
            len_rld  = 1'b1;
          // RL3: processor data entry
          end else if (hold_full) begin
            next_st          = acsm_pkg::ST_HI;
            outbuf_load_main = 1'b1;
            per_rld          = 1'b1;
          end
        end
        acsm_pkg::ST_DMA_WAIT: begin
          if (!chan_dma_on) begin
            next_st = acsm_pkg::ST_IDLE;
          // RL9: discard first word
          end else if (hold_full) begin
            next_st  = acsm_pkg::ST_DMA_PRIME;
            consume  = 1'b1;
            next_req = 1'b1;
          end
        end
        acsm_pkg::ST_DMA_PRIME: begin
          if (!chan_dma_on) begin
            next_st = acsm_pkg::ST_IDLE;
          // RL10: enter main loop
          end else if (hold_full) begin
            next_st          = acsm_pkg::ST_HI;
            outbuf_load_main = 1'b1;
            per_rld          = 1'b1;
            fire_prep        = 1'b1;
          end
        end
        acsm_pkg::ST_HI: begin
          // RL5: move on period finish
          if (per_fin) begin
            next_st = acsm_pkg::ST_LO;
            per_rld = 1'b1;
            // RL14: attach period request set
            if (attach_period) begin
              outbuf_load_attach = 1'b1;
              next_req           = chan_dma_on;
              irq_term_now       = ~chan_dma_on;
            end
          end
        end
        acsm_pkg::ST_LO: begin
          if (per_fin) begin
            per_rld = 1'b1;
            // RL6: stay if DMA is on or interrupt was cleared
            if (chan_dma_on || !chan_irq_pending) begin
              next_st          = acsm_pkg::ST_HI;
              outbuf_load_main = 1'b1;
              fire_prep        = 1'b1;
              // RL7: word transition requests
              if (napnav) begin
                next_req     = chan_dma_on;
                irq_term_now = ~chan_dma_on;
              end
            end else begin
              next_st = acsm_pkg::ST_IDLE;
            end
          end
        end
        // RL2: unused codes fall back to idle
        default: next_st = acsm_pkg::ST_IDLE;
      endcase
    end
  end

  // RL23: reset to idle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= acsm_pkg::ST_IDLE;
    end else begin
      st <= next_st;
    end
  end
  assign state_bits = st;

  // RL22: full word into holding latch
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hold      <= '0;
      hold_full <= 1'b0;
    end else begin
      if (dma_data_valid) begin
        hold <= dma_data;
      end else if (dat_wr) begin
        hold <= reg_wdata;
      end
      // A new word beats a same-cycle consume
      hold_full <= dma_data_valid | dat_wr
                   | (hold_full & ~(outbuf_load_main | outbuf_load_attach | consume));
    end
  end

  // RL20: both buffer load paths
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      outbuf  <= '0;
      vol_out <= '0;
    end else if (outbuf_load_main | outbuf_load_attach) begin
      // RL15: old bytes repeat when no new word came
      outbuf  <= hold;
      vol_out <= vol_latch;
    end
  end

  // RL19: period latch from processor or attached channel
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      per_latch <= acsm_pkg::PER_RST;
      len_latch <= acsm_pkg::LEN_RST;
      vol_latch <= acsm_pkg::VOL_RST;
    end else begin
      if (prev_per_load) begin
        per_latch <= prev_data;
      end else if (reg_wr && reg_addr == acsm_pkg::A_PER) begin
        per_latch <= reg_wdata;
      end
      if (reg_wr && reg_addr == acsm_pkg::A_LEN) begin
        len_latch <= reg_wdata;
      end
      if (prev_vol_load) begin
        vol_latch <= prev_data[VOL_W-1:0];
      end else if (reg_wr && reg_addr == acsm_pkg::A_VOL) begin
        vol_latch <= reg_wdata[VOL_W-1:0];
      end
    end
  end

  // RL5: period counter
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      per_cnt <= acsm_pkg::PER_RST;
    end else if (per_rld) begin
      per_cnt <= per_latch;
    end else if (tick && (st == acsm_pkg::ST_HI || st == acsm_pkg::ST_LO)) begin
      per_cnt <= per_cnt - 1'b1;
    end
  end

  // RL11: length counter, restart and prepared interrupt
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      len_cnt           <= acsm_pkg::LEN_RST;
      restart_pend      <= 1'b0;
      irq_term_prepared <= 1'b0;
    end else begin
      if (len_rld || (word_in && len_fin)) begin
        len_cnt <= len_latch;
      end else if (word_in) begin
        len_cnt <= len_cnt - 1'b1;
      end
      restart_pend <= (word_in & len_fin) | (restart_pend & ~next_req);
      // RL12: fire at next word start, finish wins over fire
      irq_term_prepared <= (word_in & len_fin) | (irq_term_prepared & ~fire_prep);
    end
  end

  // RL18: combined interrupt and DMA request outputs
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      chan_irq_request     <= 1'b0;
      chan_word_dma_req    <= 1'b0;
      chan_ptr_restart_req <= 1'b0;
    end else begin
      chan_irq_request     <= irq_term_now | (fire_prep & irq_term_prepared);
      chan_word_dma_req    <= next_req;
      chan_ptr_restart_req <= next_req & restart_pend;
    end
  end

  // RL16: volume forwarding, RL17: period forwarding
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fwd_per_load <= 1'b0;
      fwd_vol_load <= 1'b0;
      fwd_data     <= '0;
    end else begin
      fwd_per_load <= outbuf_load_attach;
      fwd_vol_load <= outbuf_load_main & attach_volume;
      if (outbuf_load_main | outbuf_load_attach) begin
        fwd_data <= hold;
      end
    end
  end

  // RL4: byte select, silent when attached
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dac_out <= '0;
    end else if (attached) begin
      dac_out <= '0;
    end else if (st == acsm_pkg::ST_HI) begin
      dac_out <= outbuf[15:8];
    end else if (st == acsm_pkg::ST_LO) begin
      dac_out <= outbuf[7:0];
    end else begin
      dac_out <= '0;
    end
  end

  // Control register and read port
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      attach_volume <= 1'b0;
      attach_period <= 1'b0;
    end else if (reg_wr && reg_addr == acsm_pkg::A_CTL) begin
      attach_volume <= reg_wdata[acsm_pkg::CTL_AV];
      attach_period <= reg_wdata[acsm_pkg::CTL_AP];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= '0;
    end else if (!reg_rd) begin
      reg_rdata <= '0;
    end else if (reg_addr == acsm_pkg::A_PER) begin
      reg_rdata <= per_latch;
    end else if (reg_addr == acsm_pkg::A_LEN) begin
      reg_rdata <= len_latch;
    end else if (reg_addr == acsm_pkg::A_VOL) begin
      reg_rdata <= 16'(vol_latch);
    end else if (reg_addr == acsm_pkg::A_CTL) begin
      reg_rdata <= {14'h0000, attach_period, attach_volume};
    end else if (reg_addr == acsm_pkg::A_STAT) begin
      reg_rdata <= {10'h000, restart_pend, irq_term_prepared, hold_full, st};
    end else begin
      reg_rdata <= '0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_lo_fin;
    tick && st == acsm_pkg::ST_LO && per_fin;
  endsequence
  sequence s_hi_fin;
    tick && st == acsm_pkg::ST_HI && per_fin;
  endsequence

  unused_to_idle_a: assert property ( // RL2
    tick && (st == acsm_pkg::ST_UNUSED4 || st[2:1] == 2'h3) |=> st == acsm_pkg::ST_IDLE)
    else $error("unused state did not return to idle");
  dma_start_a: assert property ( // RL8
    tick && st == acsm_pkg::ST_IDLE && chan_dma_on |=> st == acsm_pkg::ST_DMA_WAIT && chan_word_dma_req)
    else $error("DMA start missed state or request");
  discard_word_a: assert property ( // RL9
    tick && st == acsm_pkg::ST_DMA_WAIT && chan_dma_on && hold_full
    |=> st == acsm_pkg::ST_DMA_PRIME && !hold_full && chan_word_dma_req)
    else $error("first DMA word not discarded");
  hold_high_a: assert property ( // RL5
    st == acsm_pkg::ST_HI && !(tick && per_fin) |=> st == acsm_pkg::ST_HI)
    else $error("left high byte state early");
  per_reload_a: assert property ( // RL5
    s_hi_fin |=> st == acsm_pkg::ST_LO && per_cnt == $past(per_latch))
    else $error("period not reloaded on move");
  high_byte_a: assert property ( // RL4
    st == acsm_pkg::ST_HI && !attached |=> dac_out == $past(outbuf[15:8]))
    else $error("high byte not on converter");
  word_irq_a: assert property ( // RL7
    s_lo_fin and (!chan_dma_on && !chan_irq_pending && napnav) |=> st == acsm_pkg::ST_HI && chan_irq_request)
    else $error("no interrupt on word transition");
  late_clear_a: assert property ( // RL6
    s_lo_fin and (!chan_dma_on && chan_irq_pending) |=> st == acsm_pkg::ST_IDLE && !chan_irq_request)
    else $error("pending interrupt did not stop loop");
  len_restart_a: assert property ( // RL11
    word_in && len_fin && !len_rld |=> len_cnt == $past(len_latch) && restart_pend)
    else $error("length finish not handled");
  period_fwd_a: assert property ( // RL17
    s_hi_fin and attach_period |=> fwd_per_load && fwd_data == $past(hold))
    else $error("period word not forwarded");
  irq_pulse_a: assert property ( // RL18
    chan_irq_request |=> !chan_irq_request)
    else $error("interrupt request longer than one cycle");

endmodule : acsm_channel

//--- bench/acsm_far_model.sv
// Behavioural DMA controller and interrupt circuitry facing one channel
`timescale 1ns/1ps
module acsm_far_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Requests from the channel
  input  wire logic        chan_word_dma_req,
  input  wire logic        chan_ptr_restart_req,
  input  wire logic        chan_irq_request,
  // Bench controls
  input  wire logic        slow,
  input  wire logic        auto_clear,
  // Answers to the channel
  output logic             dma_data_valid,
  output logic [15:0]      dma_data,
  output logic             chan_irq_pending
);
  logic [5:0] wait_cnt;
  logic       busy;
  logic       restart;
  logic [3:0] ptr;
  logic [3:0] idx;

  assign idx = restart ? 4'h0 : ptr;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy           <= 1'b0;
      restart        <= 1'b0;
      wait_cnt       <= 6'h00;
      ptr            <= 4'h0;
      dma_data_valid <= 1'b0;
      dma_data       <= 16'h0000;
    end else begin
      dma_data_valid <= 1'b0;
      // Released bus inverts every cycle, alternating the last word and its complement
      dma_data       <= ~dma_data;
      if (chan_word_dma_req) begin
        busy     <= 1'b1;
        restart  <= chan_ptr_restart_req;
        wait_cnt <= slow ? 6'h32 : 6'h0e;
      end else if (busy && wait_cnt != 6'h00) begin
        wait_cnt <= wait_cnt - 6'h01;
      end else if (busy) begin
        busy           <= 1'b0;
        dma_data_valid <= 1'b1;
        dma_data       <= {idx, 4'hc, idx, 4'h5};
        ptr            <= idx + 4'h1;
      end
    end
  end

  // pending held until the processor clears it
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      chan_irq_pending <= 1'b0;
    end else if (chan_irq_request) begin
      chan_irq_pending <= 1'b1;
    end else if (auto_clear) begin
      chan_irq_pending <= 1'b0;
    end
  end
endmodule : acsm_far_model

//--- bench/testbench.sv
// Self-checking bench for one audio channel sequencer
`timescale 1ns/1ps
module testbench;
  logic [2:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic [15:0] rd_val;
  logic [15:0] dma_data;
  logic [15:0] prev_data;
  logic [15:0] fwd_data;
  logic [7:0]  dac_out;
  logic [6:0]  vol_out;
  logic [2:0]  state_bits;
  logic        clk, sys_rst, reg_wr, reg_rd, chan_dma_on, chan_irq_pending;
  logic        dma_data_valid, chan_word_dma_req, chan_ptr_restart_req;
  logic        chan_irq_request, prev_per_load, prev_vol_load, fwd_per_load, fwd_vol_load;
  logic        slow, auto_clear;
  int          err_total, n_compared, span, base;
  int          irq_cnt, rst_cnt, rst_alone, fvol_cnt, fper_cnt;

  acsm_channel i_dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .chan_dma_on(chan_dma_on), .chan_irq_pending(chan_irq_pending),
    .dma_data_valid(dma_data_valid), .dma_data(dma_data),
    .chan_word_dma_req(chan_word_dma_req), .chan_ptr_restart_req(chan_ptr_restart_req),
    .chan_irq_request(chan_irq_request), .prev_per_load(prev_per_load),
    .prev_vol_load(prev_vol_load), .prev_data(prev_data), .fwd_per_load(fwd_per_load),
    .fwd_vol_load(fwd_vol_load), .fwd_data(fwd_data), .dac_out(dac_out),
    .vol_out(vol_out), .state_bits(state_bits));

  acsm_far_model i_far (.clk(clk), .sys_rst(sys_rst), .chan_word_dma_req(chan_word_dma_req),
    .chan_ptr_restart_req(chan_ptr_restart_req), .chan_irq_request(chan_irq_request),
    .slow(slow), .auto_clear(auto_clear), .dma_data_valid(dma_data_valid),
    .dma_data(dma_data), .chan_irq_pending(chan_irq_pending));

  always #2.5 clk = ~clk;

  // Pulse counters on the channel outputs
  always @(posedge clk) begin
    if (chan_irq_request === 1'b1) irq_cnt++;
    if (fwd_vol_load === 1'b1) fvol_cnt++;
    if (fwd_per_load === 1'b1) fper_cnt++;
    if (chan_ptr_restart_req === 1'b1) begin
      rst_cnt++;
      if (chan_word_dma_req !== 1'b1) rst_alone++;
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  task complete_run;
    if (err_total == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : complete_run

  task reg_write(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : reg_write

  task reg_read(input logic [2:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask : reg_read

  task settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle

  // Counts edges until the state shows up; a hang ends the run
  task wait_state(input logic [2:0] st);
    span = 0;
    while (span < 4000) begin
      settle(1);
      span++;
      if (state_bits === st) return;
    end
    err_total++;
    complete_run();
  endtask : wait_state

  initial begin
    clk = 0; sys_rst = 1; reg_addr = 3'h0; reg_wdata = 16'h0000; reg_wr = 0; reg_rd = 0;
    chan_dma_on = 0; prev_per_load = 0; prev_vol_load = 0; prev_data = 16'h0000; slow = 0; auto_clear = 1;
    err_total = 0; n_compared = 0; irq_cnt = 0; rst_cnt = 0; rst_alone = 0;
    fvol_cnt = 0; fper_cnt = 0;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    settle(1);
    check(16'(state_bits), 16'h0000);
    reg_read(acsm_pkg::A_STAT); check(rd_val, 16'h0000);
    reg_read(3'h7); check(rd_val, 16'h0000);
    @(posedge clk);
    prev_data     <= 16'h0002;
    prev_per_load <= 1'b1;
    prev_vol_load <= 1'b1;
    @(posedge clk);
    prev_per_load <= 1'b0;
    prev_vol_load <= 1'b0;
    reg_read(acsm_pkg::A_PER); check(rd_val, 16'h0002);
    reg_read(acsm_pkg::A_VOL); check(rd_val, 16'h0002);
    // Processor-fed loop
    reg_write(acsm_pkg::A_PER, 16'h0003);
    reg_write(acsm_pkg::A_VOL, 16'h0040);
    reg_write(acsm_pkg::A_DAT, 16'ha55a);
    wait_state(acsm_pkg::ST_HI);
    settle(2); check(16'(dac_out), 16'h00a5);
    check(16'(vol_out), 16'h0040);
    reg_write(acsm_pkg::A_DAT, 16'hc33c);
    wait_state(acsm_pkg::ST_LO);
    settle(2); check(16'(dac_out), 16'h005a);
    base = irq_cnt;
    wait_state(acsm_pkg::ST_LO);
    // Three edges of this low phase were spent before the count started
    wait_state(acsm_pkg::ST_HI); check(16'(span), 16'(3 * acsm_pkg::TICK_DIV - 3));
    settle(3); check(16'(dac_out), 16'h00c3);
    check(16'(irq_cnt - base), 16'h0001);
    wait_state(acsm_pkg::ST_LO);
    wait_state(acsm_pkg::ST_HI);
    settle(3); check(16'(dac_out), 16'h00c3);
    @(posedge clk);
    auto_clear <= 1'b0;
    wait_state(acsm_pkg::ST_IDLE);
    check(16'(irq_cnt - base), 16'h0003);
    @(posedge clk);
    auto_clear <= 1'b1;
    // DMA-fed loop, first word thrown away
    reg_write(acsm_pkg::A_LEN, 16'h0002);
    reg_write(acsm_pkg::A_PER, 16'h0001);
    @(posedge clk);
    chan_dma_on <= 1'b1;
    wait_state(acsm_pkg::ST_DMA_WAIT);
    wait_state(acsm_pkg::ST_DMA_PRIME);
    wait_state(acsm_pkg::ST_HI);
    settle(2); check(16'(dac_out), 16'h001c);
    base = irq_cnt;
    @(posedge clk);
    slow <= 1'b1;
    settle(1200);
    check(16'(rst_alone), 16'h0000);
    check(16'(rst_cnt > 0), 16'h0001);
    check(16'(irq_cnt > base), 16'h0001);
    check(16'(state_bits[2:1]), 16'h0001);
    @(posedge clk);
    chan_dma_on <= 1'b0;
    auto_clear  <= 1'b0;
    wait_state(acsm_pkg::ST_IDLE);
    @(posedge clk);
    auto_clear <= 1'b1;
    slow       <= 1'b0;
    // Attach volume: data goes to the next channel
    reg_write(acsm_pkg::A_CTL, 16'h0001);
    base = irq_cnt;
    reg_write(acsm_pkg::A_DAT, 16'h0040);
    wait_state(acsm_pkg::ST_HI);
    settle(2); check(16'(dac_out), 16'h0000);
    wait_state(acsm_pkg::ST_LO);
    wait_state(acsm_pkg::ST_HI);
    settle(3); check(fwd_data, 16'h0040);
    check(16'(fvol_cnt > 0), 16'h0001);
    check(16'(irq_cnt > base), 16'h0001);
    // Attach period: requests only on the high-to-low move, two of them here
    reg_write(acsm_pkg::A_CTL, 16'h0002);
    base = irq_cnt;
    reg_write(acsm_pkg::A_DAT, 16'h0123);
    wait_state(acsm_pkg::ST_LO);
    wait_state(acsm_pkg::ST_HI);
    wait_state(acsm_pkg::ST_LO);
    settle(3); check(fwd_data, 16'h0123);
    check(16'(fper_cnt > 0), 16'h0001);
    check(16'(dac_out), 16'h0000);
    check(16'(irq_cnt - base), 16'h0002);
    // Reset in mid-run
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    settle(1); check(16'(state_bits), 16'h0000);
    complete_run();
  end
endmodule : testbench
